// file: mii_phy_timing_pkg.sv
// Constants and timing figures for the MII transceiver timing block.
// Assumes a 40 MHz system clock; all times become cycle counts here.
// Notes on behaviour
// - Carrier sense rises 4 BT after transmit enable; falls 8 BT (10M) or 4 BT (100M).
// - First symbol reaches the line pair 4 BT (10M) or 9 BT (100M) after enable.
// - At 10M, 2.5 us after enable falls, collision goes high for 1.0 us.
// - One bit time is 10 ns at 100 Mb/s (100 ns at 10 Mb/s).
// - At 100M receive nibbles appear 6 BT after carrier sense, code-group aligned.
// - At 100M carrier sense rises 106 to 138 ns after start-of-stream.
// - At 100M carrier sense falls 154 to 186 ns after end-of-stream.
// - Link bursts are 16 ms apart, never under 8 or over 24 ms.
// - Each clock and data mark in a burst is 100 ns wide.
// - A data mark sits 69 us after its preceding clock mark.
// - A burst holds between 17 and 33 clock-plus-data positions.
package mii_phy_timing_pkg;
    localparam int SYS_PERIOD_PS = 25_000;
    localparam int BT_100_PS = 10_000;
    localparam int BT_10_PS = 100_000;

    function automatic int ceil_cyc(input int ps);
        int c;
        c = (ps + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int floor_cyc(input int ps);
        int c;
        c = ps / SYS_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int CRS_ON_BT = 4;
    localparam int CRS_OFF_10_BT = 8;
    localparam int CRS_OFF_100_BT = 4;
    localparam int LAT_10_BT = 4;
    localparam int LAT_100_BT = 9;
    localparam int RLAT_BT = 6;
    localparam int SQE_DELAY_NS = 2500;
    localparam int SQE_WIDTH_NS = 1000;
    localparam int RX_CRS_ON_MIN_NS = 106;
    localparam int RX_CRS_OFF_MIN_NS = 154;
    localparam int FLP_INTERVAL_MS = 16;
    localparam int FLP_INTERVAL_MIN_MS = 8;
    localparam int FLP_INTERVAL_MAX_MS = 24;
    localparam int FLP_WIDTH_NS = 100;
    localparam int FLP_DATA_OFS_US = 69;
    localparam int FLP_CELL_US = 136;
    localparam int FLP_DATA_BITS = 16;
    localparam int FLP_MIN_POS = 17;
    localparam int FLP_MAX_POS = 33;

    localparam int CRS_ON_10_CYC = ceil_cyc(CRS_ON_BT * BT_10_PS);
    localparam int CRS_ON_100_CYC = ceil_cyc(CRS_ON_BT * BT_100_PS);
    localparam int CRS_OFF_10_CYC = ceil_cyc(CRS_OFF_10_BT * BT_10_PS);
    localparam int CRS_OFF_100_CYC = ceil_cyc(CRS_OFF_100_BT * BT_100_PS);
    localparam int LAT_10_CYC = ceil_cyc(LAT_10_BT * BT_10_PS);
    localparam int LAT_100_CYC = ceil_cyc(LAT_100_BT * BT_100_PS);
    localparam int RLAT_CYC = ceil_cyc(RLAT_BT * BT_100_PS);
    localparam int SQE_DELAY_CYC = ceil_cyc(SQE_DELAY_NS * 1000);
    localparam int SQE_WIDTH_CYC = ceil_cyc(SQE_WIDTH_NS * 1000);
    localparam int RX_CRS_ON_CYC = ceil_cyc(RX_CRS_ON_MIN_NS * 1000);
    localparam int RX_CRS_OFF_CYC = ceil_cyc(RX_CRS_OFF_MIN_NS * 1000);
    localparam int FLP_WIDTH_CYC = ceil_cyc(FLP_WIDTH_NS * 1000);
    localparam int FLP_DATA_OFS_CYC = ceil_cyc(FLP_DATA_OFS_US * 1000_000);
    localparam int FLP_CELL_CYC = ceil_cyc(FLP_CELL_US * 1000_000);
    localparam int FLP_INTERVAL_CYC = FLP_INTERVAL_MS * (1000_000_000 / SYS_PERIOD_PS);
    localparam int FLP_INTERVAL_MIN_CYC = FLP_INTERVAL_MIN_MS * (1000_000_000 / SYS_PERIOD_PS);
    localparam int FLP_INTERVAL_MAX_CYC = FLP_INTERVAL_MAX_MS * (1000_000_000 / SYS_PERIOD_PS);

    typedef enum logic {
        FLP_IDLE = 1'b0,
        FLP_BURST = 1'b1
    } flp_state_t;
endpackage

// file: mii_phy_timing.sv
// MII-side timing of a 10/100 transceiver: carrier sense, transmit latency,
// collision test strobe, receive alignment and fast link bursts.
// Assumes the line decoder supplies one-cycle delimiter strobes on i_sys_clk.
`timescale 1ns/10ps
module mii_phy_timing #(
    parameter int FLP_INTERVAL = mii_phy_timing_pkg::FLP_INTERVAL_CYC,
    parameter int FLP_CELL = mii_phy_timing_pkg::FLP_CELL_CYC
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // MII transmit side, from the controller
    input wire logic i_tx_clk,
    input wire logic i_tx_en,
    input wire logic [3:0] i_txd,
    // Straps
    input wire logic i_speed_100,
    input wire logic i_an_enable,
    input wire logic [15:0] i_flp_word,
    // Line decoder, same clock
    input wire logic i_rx_sos,
    input wire logic i_rx_eos,
    input wire logic [3:0] i_rx_nibble,
    // MII status and receive side
    output logic o_crs,
    output logic o_col,
    output logic o_rx_dv,
    output logic [3:0] o_rxd,
    // Line side
    output logic o_line_transmit_pair_active,
    output logic [3:0] o_line_transmit_pair_nibble,
    output logic o_flp_mark
);
    import mii_phy_timing_pkg::*;

    // Local copies of package counts, so assertion ranges use plain ints; SQE_END and DATA_END are derived ends used by the logic
    localparam int CRS_ON_MAX = CRS_ON_10_CYC;
    localparam int LAT_MAX = LAT_10_CYC;
    localparam int RX_ON_MAX = RX_CRS_ON_CYC;
    localparam int SQE_END = SQE_DELAY_CYC + SQE_WIDTH_CYC - 1;
    localparam int DATA_END = FLP_DATA_OFS_CYC + FLP_WIDTH_CYC;

    typedef struct packed {
        logic [1:0] clk_s;
        logic [2:0] en_s;
        logic [1:0] spd_s;
        logic [1:0] an_s;
        logic [11:0] txd_s;
        logic [31:0] word_s;
        logic clk_prev;
        logic tx_en;
        logic [3:0] txd;
        logic crs_tx;
        logic [7:0] crs_tx_cnt;
        logic line_act;
        logic [7:0] line_cnt;
        logic [3:0] line_nib;
        logic rx_line;
        logic crs_rx;
        logic [7:0] crs_rx_cnt;
        logic rx_dv;
        logic [7:0] rx_dv_cnt;
        logic [3:0] rxd;
        logic crs;
        logic sqe_run;
        logic [7:0] sqe_cnt;
        logic col;
        flp_state_t flp_st;
        logic [19:0] gap_cnt;
        logic [12:0] cell_cnt;
        logic [4:0] pos;
        logic flp_mark;
    } state_t;

    state_t s_q, s_d;
    logic [1:0] rst_q;
    logic rst_n;

    // Release of the asynchronous reset is retimed to avoid recovery hazards
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    // A level that lags its input by d_rise or d_fall cycles
    function automatic logic [8:0] follow(input logic in, input logic out,
            input logic [7:0] cnt, input int d_rise, input int d_fall);
        int d;
        d = in ? d_rise : d_fall;
        if (in == out) begin
            return {out, 8'h00};
        end
        if (cnt == 8'(d - 1)) begin
            return {in, 8'h00};
        end
        return {out, 8'(cnt + 8'h01)};
    endfunction

    logic spd100;
    logic an_en;
    logic tx_edge;
    logic [15:0] flp_word;
    assign spd100 = s_q.spd_s[1];
    assign an_en = s_q.an_s[1];
    assign tx_edge = s_q.clk_s[1] & ~s_q.clk_prev;
    assign flp_word = s_q.word_s[31:16];

    always_comb begin
        s_d = s_q;
        s_d.clk_s = {s_q.clk_s[0], i_tx_clk};
        s_d.en_s = {s_q.en_s[1:0], i_tx_en};
        s_d.spd_s = {s_q.spd_s[0], i_speed_100};
        s_d.an_s = {s_q.an_s[0], i_an_enable};
        s_d.txd_s = {s_q.txd_s[7:0], i_txd};
        s_d.word_s = {s_q.word_s[15:0], i_flp_word};
        s_d.clk_prev = s_q.clk_s[1];

        // Enable and data are taken on the rising edge of the transmit clock.
        // The oldest sample predates that edge, so data launched by the same
        // edge is never taken early; this needs a set-up of one system cycle.
        if (tx_edge) begin
            s_d.tx_en = s_q.en_s[2];
            s_d.txd = s_q.txd_s[11:8];
        end

        {s_d.crs_tx, s_d.crs_tx_cnt} = follow(s_q.tx_en, s_q.crs_tx, s_q.crs_tx_cnt,
            spd100 ? CRS_ON_100_CYC : CRS_ON_10_CYC,
            spd100 ? CRS_OFF_100_CYC : CRS_OFF_10_CYC);
        {s_d.line_act, s_d.line_cnt} = follow(s_q.tx_en, s_q.line_act, s_q.line_cnt,
            spd100 ? LAT_100_CYC : LAT_10_CYC,
            spd100 ? LAT_100_CYC : LAT_10_CYC);
        s_d.line_nib = s_d.line_act ? s_q.txd : 4'h0;

        // Collision test strobe after each 10 Mb/s frame
        if (s_q.sqe_run) begin
            s_d.sqe_cnt = s_q.sqe_cnt + 8'h01;
            if (s_q.sqe_cnt == 8'(SQE_DELAY_CYC - 1)) begin
                s_d.col = 1'b1;
            end
            if (s_q.sqe_cnt == 8'(SQE_END)) begin
                s_d.col = 1'b0;
                s_d.sqe_run = 1'b0;
            end
        end
        // A frame that ends during a strobe restarts its timing
        if (tx_edge && s_q.tx_en && !s_q.en_s[2] && !spd100) begin
            s_d.sqe_run = 1'b1;
            s_d.sqe_cnt = 8'h00;
            s_d.col = 1'b0;
        end

        // Receive: delimiters open and close the stream on the line
        if (i_rx_sos) begin
            s_d.rx_line = 1'b1;
        end else if (i_rx_eos) begin
            s_d.rx_line = 1'b0;
        end
        {s_d.crs_rx, s_d.crs_rx_cnt} = follow(s_q.rx_line, s_q.crs_rx, s_q.crs_rx_cnt,
            RX_CRS_ON_CYC, RX_CRS_OFF_CYC);
        {s_d.rx_dv, s_d.rx_dv_cnt} = follow(s_q.crs_rx, s_q.rx_dv, s_q.rx_dv_cnt,
            RLAT_CYC, 1);
        // Nibbles arrive code-group aligned from the decoder
        s_d.rxd = s_d.rx_dv ? i_rx_nibble : 4'h0;
        s_d.crs = s_d.crs_tx | s_d.crs_rx;

        // Fast link bursts; the gap counter saturates rather than wraps
        s_d.flp_mark = 1'b0;
        if (!an_en) begin
            s_d.flp_st = FLP_IDLE;
            s_d.gap_cnt = 20'h0_0000;
            s_d.cell_cnt = 13'h0000;
            s_d.pos = 5'h00;
        end else begin
            if (s_q.gap_cnt != 20'hF_FFFF) begin
                s_d.gap_cnt = s_q.gap_cnt + 20'h0_0001;
            end
            unique case (s_q.flp_st)
                FLP_IDLE: begin
                    if (s_q.gap_cnt >= 20'(FLP_INTERVAL - 1)) begin
                        s_d.flp_st = FLP_BURST;
                        s_d.gap_cnt = 20'h0_0000;
                        s_d.cell_cnt = 13'h0000;
                        s_d.pos = 5'h00;
                    end
                end
                FLP_BURST: begin
                    if (s_q.cell_cnt < 13'(FLP_WIDTH_CYC)) begin
                        s_d.flp_mark = 1'b1;
                    end
                    if (s_q.pos < 5'(FLP_DATA_BITS) && flp_word[s_q.pos[3:0]] &&
                            s_q.cell_cnt >= 13'(FLP_DATA_OFS_CYC) &&
                            s_q.cell_cnt < 13'(DATA_END)) begin
                        s_d.flp_mark = 1'b1;
                    end
                    if (s_q.cell_cnt == 13'(FLP_CELL - 1)) begin
                        s_d.cell_cnt = 13'h0000;
                        // Clock cells end the burst; data sits in all but the last
                        if (s_q.pos == 5'(FLP_MIN_POS - 1)) begin
                            s_d.flp_st = FLP_IDLE;
                        end else begin
                            s_d.pos = s_q.pos + 5'h01;
                        end
                    end else begin
                        s_d.cell_cnt = s_q.cell_cnt + 13'h0001;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_crs = s_q.crs;
    assign o_col = s_q.col;
    assign o_rx_dv = s_q.rx_dv;
    assign o_rxd = s_q.rxd;
    assign o_line_transmit_pair_active = s_q.line_act;
    assign o_line_transmit_pair_nibble = s_q.line_nib;
    assign o_flp_mark = s_q.flp_mark;

    a_crs_tx_on: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n)
        $rose(s_q.tx_en) |-> ##[1:CRS_ON_MAX] s_q.crs_tx)
        else $error("carrier sense late after transmit enable");

    a_line_latency: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n)
        $rose(s_q.tx_en) |-> ##[1:LAT_MAX] s_q.line_act)
        else $error("line output late after transmit enable");

    a_sqe_speed: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n)
        o_col |-> !spd100)
        else $error("collision test strobe at 100 Mb/s");

    a_sqe_width: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n)
        $rose(o_col) |-> o_col [*8])
        else $error("collision test strobe too short");

    a_rx_crs_on: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n)
        $rose(s_q.rx_line) |-> ##[1:RX_ON_MAX] s_q.crs_rx)
        else $error("receive carrier sense late");

    a_rx_align: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n)
        $rose(o_rx_dv) |-> $past(o_crs, 3) && !$past(o_crs, 4))
        else $error("receive data not aligned to carrier sense");

    a_flp_width: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n)
        $rose(o_flp_mark) |-> o_flp_mark [*4] ##1 !o_flp_mark)
        else $error("burst mark width wrong");
endmodule

// file: mii_mac_model.sv
// Behavioural MAC on the MII transmit side of the block.
// Assumes the block samples the transmit clock with its own clock.
`timescale 1ns/10ps
module mii_mac_model (
    // MII transmit
    output logic o_tx_clk,
    output logic o_tx_en,
    output logic [3:0] o_txd
);
    initial begin
        o_tx_clk = 1'b0;
        o_tx_en = 1'b0;
        o_txd = 4'h0;
    end
    // Clock stands still between frames; data moves just after each rise.
    // One extra rise after enable drops lets the block see the frame end.
    task automatic send(input int n);
        for (int i = 0; i <= n + 1; i++) begin
            #100 o_tx_clk = 1'b1;
            #1 o_tx_en = (i < n);
            o_txd = (i < n) ? 4'(i) : ~o_txd;
            #99 o_tx_clk = 1'b0;
        end
    endtask
endmodule

// file: mii_phy_timing_bench.sv
// Self-checking bench for the MII transceiver timing block.
// Assumes the MAC model drives transmit; line events come from here.
`timescale 1ns/10ps
module mii_phy_timing_bench;
    import mii_phy_timing_pkg::*;
    logic i_sys_clk, i_nrst, spd, an, sos, eos, tx_clk, tx_en, crs, col, dv, act, flp;
    logic [3:0] nib, txd, rxd;
    int num_errors = 0;
    int n_compared = 0;
    mii_mac_model u_mac (.o_tx_clk(tx_clk), .o_tx_en(tx_en), .o_txd(txd));
    mii_phy_timing #(.FLP_INTERVAL(8000)) u_dut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
        .i_tx_clk(tx_clk), .i_tx_en(tx_en), .i_txd(txd), .i_speed_100(spd),
        .i_an_enable(an), .i_flp_word(16'hFFFF), .i_rx_sos(sos), .i_rx_eos(eos),
        .i_rx_nibble(nib), .o_crs(crs), .o_col(col), .o_rx_dv(dv), .o_rxd(rxd),
        .o_line_transmit_pair_active(act), .o_line_transmit_pair_nibble(),
        .o_flp_mark(flp));
    initial begin
        i_sys_clk = 1'b0;
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end
    task automatic chk(input logic [31:0] g, e);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Loose window: sampling the link clock adds a few cycles of slop
    task automatic win(input int n, c);
        chk((n + 2 >= c && n <= c + 12) ? c : n, c);
    endtask
    task automatic till(ref logic s, input logic v, output int n);
        n = 0;
        while (s !== v && n < 9000) begin
            tick();
            n++;
        end
    endtask
    task automatic tick();
        @(posedge i_sys_clk);
        #2;
    endtask
    // Held low for a while, then released; reused as a warm reset
    task automatic rst();
        i_nrst = 1'b0;
        tick();
        tick();
        i_nrst = 1'b1;
        repeat (4) tick();
    endtask
    task automatic t_tx(input logic f);
        int a, b;
        spd = f;
        rst();
        fork
            u_mac.send(8);
            begin
                @(posedge tx_en);
                // Enable is taken at the next link clock rise
                @(posedge tx_clk);
                fork
                    till(crs, 1'b1, a);
                    till(act, 1'b1, b);
                join
                win(a, f ? CRS_ON_100_CYC : CRS_ON_10_CYC);
                win(b, f ? LAT_100_CYC : LAT_10_CYC);
                @(negedge tx_en);
                @(posedge tx_clk);
                fork
                    till(crs, 1'b0, a);
                    till(col, 1'b1, b);
                join
                win(a, f ? CRS_OFF_100_CYC : CRS_OFF_10_CYC);
                win(b, f ? 9000 : SQE_DELAY_CYC);
                till(col, 1'b0, a);
                win(a, f ? 0 : SQE_WIDTH_CYC);
            end
        join
    endtask
    task automatic t_rx();
        int a;
        spd = 1'b1;
        rst();
        nib = 4'h5;
        sos = 1'b1;
        tick();
        sos = 1'b0;
        till(crs, 1'b1, a);
        win(a, RX_CRS_ON_CYC);
        till(dv, 1'b1, a);
        win(a, RLAT_CYC);
        chk(rxd, 4'h5);
        eos = 1'b1;
        tick();
        eos = 1'b0;
        till(crs, 1'b0, a);
        win(a, RX_CRS_OFF_CYC);
    endtask
    task automatic t_flp();
        int a;
        an = 1'b1;
        rst();
        till(flp, 1'b1, a);
        till(flp, 1'b0, a);
        win(a, FLP_WIDTH_CYC);
        till(flp, 1'b1, a);
        win(a + FLP_WIDTH_CYC, FLP_DATA_OFS_CYC);
    endtask
    task automatic give_verdict();
        if (num_errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        {i_nrst, spd, an, sos, eos, nib} = 9'h000;
        t_tx(1'b0);
        t_tx(1'b1);
        t_rx();
        t_flp();
        give_verdict();
    end
    initial begin
        #2_000_000;
        num_errors++;
        give_verdict();
    end
endmodule
